// [logic/acs_control.sv]
`include "acs_params.svh"

module acs_control (
    input wire logic CORE_CLK, // System clock
    input wire logic RESETN, // Synchronous reset, active low
    input wire acs_pkg::acs_sfr_req_type SFR_REQ, // Register access from the core
    output logic [7:0] SFR_RDATA, // Read data, valid the cycle after a read
    input wire logic CONV_VALID, // Converter result strobe
    input wire logic [23:0] CONV_DATA, // Raw two's complement converter result
    input wire logic CONV_POWER_DOWN, // Converter powered down
    input wire logic AUX_EVENT, // Auxiliary interrupt source event
    input wire logic WDT_EVENT, // Watchdog expiry event
    input wire logic WDT_RESET_DISABLE, // Watchdog reset action disabled
    input wire logic [2:0] DECIM_HIGH, // Upper decimation ratio bits
    output logic [23:0] GAIN_CAL, // Gain calibration word
    output logic [3:0] PLUS_CHANNEL_SELECT, // Positive input code
    output logic [3:0] MINUS_CHANNEL_SELECT, // Negative input code
    output logic TEMP_SENSOR_SELECT, // Temperature sensor routed
    output acs_pkg::acs_front_type FRONT_CFG, // Front-end configuration
    output logic [7:0] GAIN_FACTOR, // Programmable gain value
    output logic RESULT_SIGN_FORMAT, // 1 unipolar, 0 bipolar
    output logic [1:0] SETTLING_FILTER_SELECT, // Filter type
    output logic CAL_START, // One-cycle calibration start
    output logic [2:0] CAL_MODE, // Calibration mode of last start
    output logic [10:0] DECIM_RATIO, // Decimation ratio
    output logic AUX_IRQ, // Auxiliary interrupt request
    output logic WDT_IRQ, // Watchdog interrupt request
    output logic WDT_RESET_REQ, // Watchdog reset request
    output logic CONV_IRQ, // Converter result interrupt
    output logic SUM_IRQ, // Summation complete interrupt
    output logic SUM_OVERFLOW // Summation contents invalid
);

    localparam acs_pkg::acs_state_type RESET_STATE = '{
        gain_cal: {`ACS_RST_GAIN_HIGH, `ACS_RST_GAIN_MID, `ACS_RST_GAIN_LOW},
        chan: `ACS_RST_CHAN,
        front: `ACS_RST_FRONT,
        decim_low: `ACS_RST_DECIM_LOW,
        acc_ctrl: `ACS_RST_ACC_CTRL,
        sum_state: acs_pkg::ACS_SUM_IDLE,
        default: '0
    };

    acs_pkg::acs_state_type q;
    acs_pkg::acs_state_type d;

    function automatic logic [8:0] sum_target(input logic [2:0] code);
        sum_target = 9'(10'h002 << code);
    endfunction

    function automatic logic [31:0] extend(input logic [23:0] v, input logic bipolar);
        extend = {{8{bipolar & v[23]}}, v};
    endfunction

    // Bit 32 of the result carries the overflow or underflow indication
    function automatic logic [32:0] arith(input logic [31:0] a, input logic [31:0] b,
                                          input logic sub, input logic bipolar);
        logic [32:0] r;
        r = sub ? ({bipolar & a[31], a} - {bipolar & b[31], b})
                : ({bipolar & a[31], a} + {bipolar & b[31], b});
        arith = {(bipolar ? (r[32] ^ r[31]) : r[32]), r[31:0]};
    endfunction

    function automatic logic [31:0] shift_sum(input logic [31:0] v, input logic [2:0] code,
                                              input logic bipolar);
        logic [3:0] amount;
        amount = {1'b0, code} + 4'h1;
        shift_sum = bipolar ? 32'($signed(v) >>> amount) : (v >> amount);
    endfunction

    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] mode;
    logic [23:0] formatted;
    logic [32:0] op_res;
    logic [8:0] next_count;
    logic [31:0] new_operand;

    assign wr = SFR_REQ.wr;
    assign rd = SFR_REQ.rd;
    assign addr = SFR_REQ.addr;
    assign wdata = SFR_REQ.wdata;

    always_comb begin
        d = q;
        mode = q.acc_ctrl[7:6];
        op_res = '0;
        next_count = q.count + 9'h001;
        new_operand = {q.operand[31:8], wdata};
        d.cal_start = 1'b0;

        // Unipolar coding clamps negative inputs and doubles the span
        if (q.sign_fmt) begin
            formatted = CONV_DATA[23] ? 24'h000000 : {CONV_DATA[22:0], CONV_DATA[22]};
        end else begin
            formatted = CONV_DATA;
        end

        // Register writes
        if (wr) begin
            if (addr == `ACS_ADDR_GAIN_LOW) begin
                d.gain_cal[7:0] = wdata;
            end else if (addr == `ACS_ADDR_GAIN_MID) begin
                d.gain_cal[15:8] = wdata;
            end else if (addr == `ACS_ADDR_GAIN_HIGH) begin
                d.gain_cal[23:16] = wdata;
            end else if (addr == `ACS_ADDR_CHAN) begin
                d.chan = wdata;
            end else if (addr == `ACS_ADDR_AUX_CTRL) begin
                d.aux_en = wdata[`ACS_BIT_AUX_EN];
                d.aux_flag = wdata[`ACS_BIT_AUX_FLAG];
                d.wdt_flag = wdata[`ACS_BIT_WDT_FLAG];
            end else if (addr == `ACS_ADDR_FRONT) begin
                d.front = wdata[6:0];
            end else if (addr == `ACS_ADDR_FILTER) begin
                if (!wdata[`ACS_BIT_SUM_OVF]) begin
                    d.sum_ovf = 1'b0;
                end
                d.sign_fmt = wdata[`ACS_BIT_SIGN_FMT];
                d.settle = wdata[5:4];
                if (wdata[2:0] != `ACS_CAL_NONE && wdata[2:0] <= `ACS_CAL_LAST) begin
                    d.cal_start = 1'b1;
                    d.cal_mode = wdata[2:0];
                end
            end else if (addr == `ACS_ADDR_DECIM_LOW) begin
                d.decim_low = wdata;
            end else if (addr >= `ACS_ADDR_SUM0 && addr <= `ACS_ADDR_SUM3) begin
                case (addr[1:0])
                    2'h2: d.operand[7:0] = wdata;
                    2'h3: d.operand[15:8] = wdata;
                    2'h0: d.operand[23:16] = wdata;
                    default: d.operand[31:24] = wdata;
                endcase
            end
        end

        // Result capture and its interrupt; the set wins over the read clear
        if (rd && addr == `ACS_ADDR_RES_LOW) begin
            d.adc_irq = 1'b0;
        end
        if (CONV_VALID) begin
            d.result = formatted;
            d.adc_irq = 1'b1;
        end
        if (AUX_EVENT) begin
            d.aux_flag = 1'b1;
        end
        if (WDT_EVENT && WDT_RESET_DISABLE) begin
            d.wdt_flag = 1'b1;
        end
        if (rd && addr == `ACS_ADDR_SUM0) begin
            d.sum_irq = 1'b0;
        end

        // Summation and shifter
        if (CONV_POWER_DOWN) begin
            d.sum_state = acs_pkg::ACS_SUM_IDLE;
            d.count = '0;
        end else if (wr && addr == `ACS_ADDR_ACC_CTRL) begin
            d.acc_ctrl = wdata;
            d.count = '0;
            d.sum_state = acs_pkg::ACS_SUM_IDLE;
            if (wdata == 8'h00) begin
                d.sum = '0;
            end else if (wdata[7:6] == `ACS_MODE_SHIFT) begin
                d.sum = shift_sum(q.sum, wdata[2:0], q.sign_fmt);
            end else if (wdata[7:6] != `ACS_MODE_CPU) begin
                d.sum_state = acs_pkg::ACS_SUM_RUN;
            end
        end else if (wr && addr == `ACS_ADDR_SUM0 && mode == `ACS_MODE_CPU) begin
            if (q.acc_ctrl[5:3] == `ACS_CNT_CPU_ADD || q.acc_ctrl[5:3] == `ACS_CNT_CPU_SUB) begin
                op_res = arith(q.sum, new_operand,
                               q.acc_ctrl[5:3] == `ACS_CNT_CPU_SUB, !q.sign_fmt);
                d.sum = op_res[31:0];
                if (op_res[32]) begin
                    d.sum_ovf = 1'b1;
                end
            end
        end else begin
            case (q.sum_state)
                acs_pkg::ACS_SUM_RUN: begin
                    if (CONV_VALID) begin
                        op_res = arith(q.sum, extend(formatted, !q.sign_fmt),
                                       1'b0, !q.sign_fmt);
                        d.sum = op_res[31:0];
                        if (op_res[32]) begin
                            d.sum_ovf = 1'b1;
                        end
                        d.count = next_count;
                        if (next_count == sum_target(q.acc_ctrl[5:3])) begin
                            if (mode == `ACS_MODE_SUM_SHIFT) begin
                                d.sum_state = acs_pkg::ACS_SUM_SHIFT;
                            end else begin
                                d.sum_state = acs_pkg::ACS_SUM_IDLE;
                                d.sum_irq = 1'b1;
                            end
                        end
                    end
                end
                acs_pkg::ACS_SUM_SHIFT: begin
                    d.sum = shift_sum(q.sum, q.acc_ctrl[2:0], q.sign_fmt);
                    d.sum_state = acs_pkg::ACS_SUM_IDLE;
                    d.sum_irq = 1'b1;
                end
                default: begin
                    d.sum_state = acs_pkg::ACS_SUM_IDLE;
                end
            endcase
        end

        // Registered read data; unmapped addresses read zero
        d.rdata = 8'h00;
        if (rd) begin
            if (addr == `ACS_ADDR_GAIN_LOW) begin
                d.rdata = q.gain_cal[7:0];
            end else if (addr == `ACS_ADDR_GAIN_MID) begin
                d.rdata = q.gain_cal[15:8];
            end else if (addr == `ACS_ADDR_GAIN_HIGH) begin
                d.rdata = q.gain_cal[23:16];
            end else if (addr == `ACS_ADDR_CHAN) begin
                d.rdata = q.chan;
            end else if (addr == `ACS_ADDR_AUX_CTRL) begin
                d.rdata = `ACS_AUX_CTRL_FIXED | {2'b00, q.aux_en, q.aux_flag, q.wdt_flag, 3'b000};
            end else if (addr == `ACS_ADDR_RES_LOW) begin
                d.rdata = q.result[7:0];
            end else if (addr == `ACS_ADDR_RES_MID) begin
                d.rdata = q.result[15:8];
            end else if (addr == `ACS_ADDR_RES_HIGH) begin
                d.rdata = q.result[23:16];
            end else if (addr == `ACS_ADDR_FRONT) begin
                d.rdata = {1'b0, q.front};
            end else if (addr == `ACS_ADDR_FILTER) begin
                d.rdata = {q.sum_ovf, q.sign_fmt, q.settle, 4'h0};
            end else if (addr == `ACS_ADDR_DECIM_LOW) begin
                d.rdata = q.decim_low;
            end else if (addr == `ACS_ADDR_ACC_CTRL) begin
                d.rdata = q.acc_ctrl;
            end else if (addr >= `ACS_ADDR_SUM0 && addr <= `ACS_ADDR_SUM3) begin
                case (addr[1:0])
                    2'h2: d.rdata = q.sum[7:0];
                    2'h3: d.rdata = q.sum[15:8];
                    2'h0: d.rdata = q.sum[23:16];
                    default: d.rdata = q.sum[31:24];
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign SFR_RDATA = q.rdata;
    assign GAIN_CAL = q.gain_cal;
    assign PLUS_CHANNEL_SELECT = q.chan[7:4];
    assign MINUS_CHANNEL_SELECT = q.chan[3:0];
    assign TEMP_SENSOR_SELECT = (q.chan == `ACS_TEMP_SENSOR_CODE);
    assign FRONT_CFG = q.front;
    assign GAIN_FACTOR = 8'(9'h001 << q.front.pga_code);
    assign RESULT_SIGN_FORMAT = q.sign_fmt;
    assign SETTLING_FILTER_SELECT = q.settle;
    assign CAL_START = q.cal_start;
    assign CAL_MODE = q.cal_mode;
    assign DECIM_RATIO = {DECIM_HIGH, q.decim_low};
    assign AUX_IRQ = q.aux_en & q.aux_flag;
    assign WDT_IRQ = q.wdt_flag;
    assign WDT_RESET_REQ = WDT_EVENT & ~WDT_RESET_DISABLE;
    assign CONV_IRQ = q.adc_irq;
    assign SUM_IRQ = q.sum_irq;
    assign SUM_OVERFLOW = q.sum_ovf;

endmodule // acs_control

// [logic/acs_params.svh]
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Special function register addresses
`define ACS_ADDR_GAIN_LOW 8'hD4
`define ACS_ADDR_GAIN_MID 8'hD5
`define ACS_ADDR_GAIN_HIGH 8'hD6
`define ACS_ADDR_CHAN 8'hD7
`define ACS_ADDR_AUX_CTRL 8'hD8
`define ACS_ADDR_RES_LOW 8'hD9
`define ACS_ADDR_RES_MID 8'hDA
`define ACS_ADDR_RES_HIGH 8'hDB
`define ACS_ADDR_FRONT 8'hDC
`define ACS_ADDR_FILTER 8'hDD
`define ACS_ADDR_DECIM_LOW 8'hDE
`define ACS_ADDR_ACC_CTRL 8'hE1
`define ACS_ADDR_SUM0 8'hE2
`define ACS_ADDR_SUM3 8'hE5

// Reset values
`define ACS_RST_GAIN_LOW 8'h00
`define ACS_RST_GAIN_MID 8'h00
`define ACS_RST_GAIN_HIGH 8'h5F
`define ACS_RST_CHAN 8'h01
`define ACS_RST_FRONT 7'h30
`define ACS_RST_DECIM_LOW 8'h1B
`define ACS_RST_ACC_CTRL 8'h00

// Field positions, fixed read bits and sensor code
`define ACS_BIT_AUX_EN 5
`define ACS_BIT_AUX_FLAG 4
`define ACS_BIT_WDT_FLAG 3
`define ACS_BIT_SUM_OVF 7
`define ACS_BIT_SIGN_FMT 6
`define ACS_AUX_CTRL_FIXED 8'h40
`define ACS_TEMP_SENSOR_CODE 8'hFF

// Accumulate modes, CPU arithmetic counts and calibration codes
`define ACS_MODE_CPU 2'h0
`define ACS_MODE_ADC_SUM 2'h1
`define ACS_MODE_SHIFT 2'h2
`define ACS_MODE_SUM_SHIFT 2'h3
`define ACS_CNT_CPU_ADD 3'h2
`define ACS_CNT_CPU_SUB 3'h4
`define ACS_CAL_NONE 3'h0
`define ACS_CAL_LAST 3'h5

`endif

// [logic/acs_pkg.sv]
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_SUM_IDLE,
        ACS_SUM_RUN,
        ACS_SUM_SHIFT
    } acs_sum_state_type;

    typedef struct packed {
        logic open_detect;
        logic vref_enable;
        logic vref_high;
        logic buffer_enable;
        logic [2:0] pga_code;
    } acs_front_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acs_sfr_req_type;

    typedef struct packed {
        logic [23:0] gain_cal;
        logic [7:0] chan;
        logic aux_en;
        logic aux_flag;
        logic wdt_flag;
        logic [23:0] result;
        logic adc_irq;
        acs_front_type front;
        logic sum_ovf;
        logic sign_fmt;
        logic [1:0] settle;
        logic [7:0] decim_low;
        logic [7:0] acc_ctrl;
        logic [31:0] sum;
        logic [31:0] operand;
        logic [8:0] count;
        acs_sum_state_type sum_state;
        logic sum_irq;
        logic cal_start;
        logic [2:0] cal_mode;
        logic [7:0] rdata;
    } acs_state_type;

endpackage

// [tb/acs_control_chk.sv]
module acs_control_chk (
    input wire logic CORE_CLK, // Clock
    input wire logic RESETN, // Reset
    input wire acs_pkg::acs_sfr_req_type SFR_REQ, // Register access
    input wire logic CONV_VALID, // Result strobe
    input wire logic WDT_EVENT, // Watchdog expiry
    input wire logic WDT_RESET_DISABLE, // Interrupt path select
    input wire logic [2:0] DECIM_HIGH, // Upper ratio bits
    input wire logic [3:0] PLUS_CHANNEL_SELECT, // Positive input
    input wire logic [3:0] MINUS_CHANNEL_SELECT, // Negative input
    input wire logic TEMP_SENSOR_SELECT, // Sensor routed
    input wire acs_pkg::acs_front_type FRONT_CFG, // Front end
    input wire logic [7:0] GAIN_FACTOR, // Gain value
    input wire logic CAL_START, // Calibration start
    input wire logic [2:0] CAL_MODE, // Calibration mode
    input wire logic [10:0] DECIM_RATIO, // Ratio
    input wire logic WDT_IRQ, // Watchdog irq
    input wire logic WDT_RESET_REQ, // Watchdog reset
    input wire logic CONV_IRQ, // Result irq
    input wire logic SUM_OVERFLOW // Sum invalid
);
    timeunit 1ns;
    timeprecision 1ps;
    acs_pkg::acs_sfr_req_type req_q;
    always_ff @(posedge CORE_CLK) req_q <= SFR_REQ;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    chk_wdt_reset_path: assert property (WDT_RESET_REQ == (WDT_EVENT && !WDT_RESET_DISABLE))
        else $error("watchdog reset request wrong");
    chk_wdt_flag_set: assert property (WDT_EVENT && WDT_RESET_DISABLE |=> WDT_IRQ)
        else $error("watchdog flag not set");
    chk_gain_factor: assert property (GAIN_FACTOR == (8'h01 << FRONT_CFG.pga_code))
        else $error("gain factor wrong");
    chk_temp_route: assert property (TEMP_SENSOR_SELECT ==
        (PLUS_CHANNEL_SELECT == 4'hF && MINUS_CHANNEL_SELECT == 4'hF))
        else $error("sensor routing wrong");
    chk_chan_write: assert property (req_q.wr && req_q.addr == 8'hD7 |->
        {PLUS_CHANNEL_SELECT, MINUS_CHANNEL_SELECT} == req_q.wdata)
        else $error("channel write not applied");
    chk_conv_set: assert property (CONV_VALID |=> CONV_IRQ)
        else $error("result irq not set");
    chk_conv_clear: assert property (SFR_REQ.rd && SFR_REQ.addr == 8'hD9 && !CONV_VALID
        |=> !CONV_IRQ)
        else $error("result irq not cleared");
    chk_decim_join: assert property (DECIM_RATIO[10:8] == DECIM_HIGH)
        else $error("ratio high bits wrong");
    chk_cal_cause: assert property (CAL_START |-> req_q.wr && req_q.addr == 8'hDD
        && CAL_MODE == req_q.wdata[2:0] && CAL_MODE inside {[3'h1:3'h5]})
        else $error("calibration start without valid write");
    chk_ovf_hold: assert property (SUM_OVERFLOW && !(SFR_REQ.wr && SFR_REQ.addr == 8'hDD
        && !SFR_REQ.wdata[7]) |=> SUM_OVERFLOW)
        else $error("overflow flag dropped");
endmodule // acs_control_chk

bind acs_control acs_control_chk chk_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .SFR_REQ(SFR_REQ), .CONV_VALID(CONV_VALID), .WDT_EVENT(WDT_EVENT),
    .WDT_RESET_DISABLE(WDT_RESET_DISABLE), .DECIM_HIGH(DECIM_HIGH),
    .PLUS_CHANNEL_SELECT(PLUS_CHANNEL_SELECT), .MINUS_CHANNEL_SELECT(MINUS_CHANNEL_SELECT),
    .TEMP_SENSOR_SELECT(TEMP_SENSOR_SELECT), .FRONT_CFG(FRONT_CFG),
    .GAIN_FACTOR(GAIN_FACTOR), .CAL_START(CAL_START), .CAL_MODE(CAL_MODE),
    .DECIM_RATIO(DECIM_RATIO), .WDT_IRQ(WDT_IRQ), .WDT_RESET_REQ(WDT_RESET_REQ),
    .CONV_IRQ(CONV_IRQ), .SUM_OVERFLOW(SUM_OVERFLOW));

// [tb/acs_control_tb_top.sv]
module acs_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, resetn, conv_pd, aux_ev, wdt_ev, wdt_rdis, go, wrs, conv_valid;
    logic [2:0] decim_hi;
    logic [23:0] code, conv_data;
    logic [7:0] rdata;
    logic [31:0] s;
    acs_pkg::acs_sfr_req_type req;
    int fails, compares;
    logic [7:0] rdo, gfac;
    logic [23:0] gcal;
    logic [3:0] pch, mch;
    logic [1:0] sflt;
    logic [2:0] cmd;
    logic [10:0] drat;
    logic tsel, sfmt, cst, airq, wirq, wrst, cirq, sirq, sovf;
    acs_pkg::acs_front_type fcfg;
    logic [7:0] ra [9] = '{8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hDC, 8'hDD, 8'hDE, 8'hE1};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h5F, 8'h01, 8'h40, 8'h30, 8'h00, 8'h1B, 8'h00};

    acs_control dut (.CORE_CLK(core_clk), .RESETN(resetn), .SFR_REQ(req), .SFR_RDATA(rdo),
        .CONV_VALID(conv_valid), .CONV_DATA(conv_data), .CONV_POWER_DOWN(conv_pd),
        .AUX_EVENT(aux_ev), .WDT_EVENT(wdt_ev), .WDT_RESET_DISABLE(wdt_rdis),
        .DECIM_HIGH(decim_hi), .GAIN_CAL(gcal), .PLUS_CHANNEL_SELECT(pch),
        .MINUS_CHANNEL_SELECT(mch), .TEMP_SENSOR_SELECT(tsel), .FRONT_CFG(fcfg),
        .GAIN_FACTOR(gfac), .RESULT_SIGN_FORMAT(sfmt), .SETTLING_FILTER_SELECT(sflt),
        .CAL_START(cst), .CAL_MODE(cmd), .DECIM_RATIO(drat), .AUX_IRQ(airq),
        .WDT_IRQ(wirq), .WDT_RESET_REQ(wrst), .CONV_IRQ(cirq), .SUM_IRQ(sirq),
        .SUM_OVERFLOW(sovf));
    acs_conv_model conv (.core_clk(core_clk), .go(go), .code(code),
        .conv_valid(conv_valid), .conv_data(conv_data));

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1;
        d = rdo;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a, rdata);
        chk($sformatf("register %0h", a), {24'h0, rdata}, {24'h0, e});
    endtask
    // Reads n bytes upward from a, low byte first
    task automatic rs(input logic [7:0] a, input int n, output logic [31:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            rd(8'(a + i), rdata);
            v[8*i+:8] = rdata;
        end
    endtask
    // Operand bytes high to low so the low-byte write comes last
    task automatic op(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) wr(8'(8'hE2 + i), v[8*i+:8]);
    endtask
    task automatic cv(input logic [23:0] d);
        @(posedge core_clk);
        go <= 1'b1;
        code <= d;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic ev(input logic w);
        @(posedge core_clk);
        if (w) wdt_ev <= 1'b1;
        else aux_ev <= 1'b1;
        #1;
        wrs = wrst;
        @(posedge core_clk);
        wdt_ev <= 1'b0;
        aux_ev <= 1'b0;
        #1;
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        req = '0;
        {conv_pd, aux_ev, wdt_ev, wdt_rdis, go, code} = '0;
        decim_hi = 3'h5;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
        rc(8'hD0, 8'h00);
        chk("ratio", 32'(drat), 32'h51B);
        wr(8'hDE, 8'hC4);
        chk("ratio", 32'(drat), 32'h5C4);
        op(32'h00563412);
        wr(8'hD4, 8'h12);
        wr(8'hD5, 8'h34);
        wr(8'hD6, 8'h56);
        chk("gain cal", 32'(gcal), 32'h563412);
        wr(8'hD7, 8'hFF);
        chk("channels", 32'({pch, mch, tsel}), 32'h1FF);
        wr(8'hD7, 8'hF7);
        chk("channels", 32'({pch, mch, tsel}), 32'h1EE);
        wr(8'hD7, 8'h80);
        chk("channels", 32'({pch, mch, tsel}), 32'h100);
        for (int i = 0; i < 8; i++) begin
            wr(8'hDC, {5'h09, i[2:0]});
            chk("gain", 32'(gfac), 32'(1 << i));
        end
        chk("front", 32'(fcfg), 32'h4F);
        for (int i = 0; i < 8; i++) begin
            wr(8'hDD, {2'b00, i[1:0], 1'b0, i[2:0]});
            chk("cal start", 32'(cst), 32'(i inside {[1:5]}));
            chk("filter", 32'(sflt), 32'(i[1:0]));
        end
        rc(8'hDD, 8'h30);
        chk("cal mode", 32'(cmd), 32'h5);
        wr(8'hD8, 8'h20);
        ev(1'b0);
        chk("aux irq", 32'(airq), 32'h1);
        wr(8'hD8, 8'h00);
        chk("aux irq", 32'(airq), 32'h0);
        wr(8'hD8, 8'h10);
        chk("aux irq", 32'(airq), 32'h0);
        wr(8'hD8, 8'h30);
        chk("aux irq", 32'(airq), 32'h1);
        rc(8'hD8, 8'h70);
        wr(8'hD8, 8'h00);
        ev(1'b1);
        chk("wdt reset", 32'(wrs), 32'h1);
        chk("wdt irq", 32'(wirq), 32'h0);
        @(posedge core_clk) wdt_rdis <= 1'b1;
        ev(1'b1);
        chk("wdt reset", 32'(wrs), 32'h0);
        chk("wdt irq", 32'(wirq), 32'h1);
        wr(8'hD8, 8'h00);
        chk("wdt irq", 32'(wirq), 32'h0);
        wr(8'hD8, 8'h08);
        chk("wdt irq", 32'(wirq), 32'h1);
        cv(24'h123456);
        chk("conv irq", 32'(cirq), 32'h1);
        rs(8'hD9, 3, s);
        chk("result", s, 32'h123456);
        chk("conv irq", 32'(cirq), 32'h0);
        wr(8'hDD, 8'h40);
        chk("format", 32'(sfmt), 32'h1);
        cv(24'h7FFFFF);
        rs(8'hD9, 3, s);
        chk("unipolar", s, 32'hFFFFFF);
        cv(24'h800000);
        rs(8'hD9, 3, s);
        chk("unipolar", s, 32'h000000);
        wr(8'hDD, 8'h00);
        wr(8'hE1, 8'h00);
        wr(8'hE1, 8'h40);
        cv(24'hFFFFFE);
        chk("sum irq", 32'(sirq), 32'h0);
        cv(24'h000001);
        chk("sum irq", 32'(sirq), 32'h1);
        rs(8'hE2, 4, s);
        chk("sum", s, 32'hFFFFFFFF);
        chk("sum irq", 32'(sirq), 32'h0);
        wr(8'hE1, 8'h48);
        for (int i = 0; i < 4; i++) begin
            cv(24'h000001);
            chk("sum irq", 32'(sirq), 32'(i == 3));
        end
        // Clear the completion interrupt so the next run must raise it again
        rd(8'hE2, rdata);
        chk("sum irq", 32'(sirq), 32'h0);
        wr(8'hE1, 8'h00);
        wr(8'hE1, 8'hC0);
        cv(24'h000004);
        chk("sum irq", 32'(sirq), 32'h0);
        cv(24'h000002);
        chk("sum irq", 32'(sirq), 32'h1);
        rs(8'hE2, 4, s);
        chk("sum shift", s, 32'h3);
        wr(8'hE1, 8'h80);
        rs(8'hE2, 4, s);
        chk("shift only", s, 32'h1);
        wr(8'hE1, 8'h00);
        rs(8'hE2, 4, s);
        chk("cleared", s, 32'h0);
        wr(8'hE1, 8'h10);
        op(32'h7FFFFFFF);
        chk("overflow", 32'(sovf), 32'h0);
        op(32'h00000001);
        chk("overflow", 32'(sovf), 32'h1);
        rs(8'hE2, 4, s);
        chk("cpu add", s, 32'h80000000);
        wr(8'hDD, 8'h80);
        chk("overflow", 32'(sovf), 32'h1);
        wr(8'hDD, 8'h00);
        chk("overflow", 32'(sovf), 32'h0);
        wr(8'hE1, 8'h00);
        wr(8'hE1, 8'h20);
        op(32'h00000001);
        rs(8'hE2, 4, s);
        chk("cpu sub", s, 32'hFFFFFFFF);
        wr(8'hE1, 8'h00);
        @(posedge core_clk) conv_pd <= 1'b1;
        wr(8'hE1, 8'h40);
        cv(24'h000005);
        cv(24'h000005);
        chk("sum irq", 32'(sirq), 32'h0);
        @(posedge core_clk) conv_pd <= 1'b0;
        rs(8'hE2, 4, s);
        chk("halted sum", s, 32'h0);
        summarize();
    end
endmodule // acs_control_tb_top

// [tb/acs_conv_model.sv]
module acs_conv_model (
    input wire logic core_clk, // Clock
    input wire logic go, // Deliver one result
    input wire logic [23:0] code, // Result to deliver
    output logic conv_valid, // Result strobe
    output logic [23:0] conv_data // Result, scrambled outside the strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        conv_valid = 1'b0;
        conv_data = 24'h000000;
    end
    // Data is inverted each idle cycle so a stale value never reads as valid
    always @(posedge core_clk) begin
        conv_valid <= go;
        conv_data <= go ? code : ~conv_data;
    end
endmodule // acs_conv_model
